// >>> verilog/lvdc_top.sv
// Purpose: Low voltage detect control and reset cause flags.
// Assumes: Processor accesses are single-cycle strobes on clk.
// Notes:   Comparators and level selection are outside this block.
`include "lvdc_defines.svh"

module lvdc_top (
  input  wire logic               clk,           // 20 MHz system clock.
  input  wire logic               resetn,        // External reset, low.
  input  wire lvdc_pkg::lvdc_addr_t cpu_addr,    // Access address.
  input  wire logic               cpu_wr,        // Byte write strobe.
  input  wire logic               cpu_bit_wr,    // Single-bit write strobe.
  input  wire logic [2:0]         cpu_bit_sel,   // Bit number for bit write.
  input  wire logic               cpu_bit_val,   // Value for bit write.
  input  wire lvdc_pkg::lvdc_byte_t cpu_wdata,   // Byte write data.
  input  wire logic               cpu_rd,        // Read strobe.
  input  wire logic               supply_low,    // Detector comparator.
  input  wire logic               poc_low,       // Power-on-clear comparator.
  input  wire logic               supply_ramp,   // Power-up in progress.
  input  wire logic               wdog_reset_req, // Watchdog reset request.
  input  wire logic               clkmon_reset_req, // Clock monitor request.
  output lvdc_pkg::lvdc_byte_t    cpu_rdata,     // Read data.
  output logic                    cpu_rvalid,    // Read data valid pulse.
  output logic                    detect_enable, // Comparator run.
  output logic                    reference_gen_enable, // Reference on.
  output logic                    low_supply_irq, // Interrupt request.
  output logic                    internal_reset, // Internal reset out.
  output lvdc_pkg::lvdc_byte_t    reset_cause_flags // Reset cause register.
);

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic lvdc_hit(input lvdc_pkg::lvdc_addr_t a,
                                    input lvdc_pkg::lvdc_addr_t target);
    lvdc_hit = (a == target);
  endfunction

  lvdc_sync_if sif ();

  assign sif.raw[`LVDC_SYNC_LOWV] = supply_low;
  assign sif.raw[`LVDC_SYNC_POC]  = poc_low;
  assign sif.raw[`LVDC_SYNC_RAMP] = supply_ramp;

  lvdc_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .sif    (sif)
  );

  logic low_synced;
  logic poc_active;

  assign low_synced = sif.synced[`LVDC_SYNC_LOWV];
  // Power-up and the power-on-clear comparator both hold the power-on-clear reset.
  assign poc_active = sif.synced[`LVDC_SYNC_POC] |
                      sif.synced[`LVDC_SYNC_RAMP];

  //////////////////////////////////////////////////////////////////////////////

  logic                 enable_reg;
  logic                 refgen_reg;
  logic                 action_reg;
  logic                 flag_reg;
  logic                 irq_reg;
  logic                 lowv_reset_reg;
  logic                 int_reset_reg;
  lvdc_pkg::lvdc_byte_t cause_reg;
  lvdc_pkg::lvdc_byte_t rdata_reg;
  logic                 rvalid_reg;

  lvdc_pkg::lvdc_byte_t ctrl_value;
  lvdc_pkg::lvdc_byte_t ctrl_next;
  logic                 ctrl_write;
  logic                 lowv_reset_now;
  logic                 other_reset_now;

  always_comb
  begin
    ctrl_value = `LVDC_CTRL_RESET;
    ctrl_value[`LVDC_BIT_ENABLE] = enable_reg;
    ctrl_value[`LVDC_BIT_REFGEN] = refgen_reg;
    ctrl_value[`LVDC_BIT_ACTION] = action_reg;
    ctrl_value[`LVDC_BIT_FLAG]   = flag_reg;
  end

  // A bit write is a read-modify-write of the current value.
  always_comb
  begin
    ctrl_next = ctrl_value;
    if (cpu_wr)
      ctrl_next = cpu_wdata;
    else if (cpu_bit_wr)
      ctrl_next[cpu_bit_sel] = cpu_bit_val;
  end

  assign ctrl_write = (cpu_wr | cpu_bit_wr) &
                      lvdc_hit(cpu_addr, `LVDC_CTRL_ADDR);

  assign lowv_reset_now  = lowv_reset_reg;
  assign other_reset_now = poc_active | wdog_reset_req | clkmon_reset_req;

  //////////////////////////////////////////////////////////////////////////////
  // Control bits. A low voltage reset alone leaves them as they are, so
  // software can still see the mode it chose after such a reset.

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      enable_reg <= 1'b0;
      refgen_reg <= 1'b0;
      action_reg <= 1'b0;
    end
    else if (other_reset_now)
    begin
      enable_reg <= 1'b0;
      refgen_reg <= 1'b0;
      action_reg <= 1'b0;
    end
    else if (ctrl_write && !lowv_reset_now)
    begin
      enable_reg <= ctrl_next[`LVDC_BIT_ENABLE];
      refgen_reg <= ctrl_next[`LVDC_BIT_REFGEN];
      action_reg <= ctrl_next[`LVDC_BIT_ACTION];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flag and its two consequences. The flag ignores writes; it only tracks
  // the synchronised comparator while detection runs.

  always_ff @(posedge clk)
  begin
    if (!resetn)
      flag_reg <= 1'b0;
    else
      flag_reg <= low_synced & enable_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= flag_reg & enable_reg & ~action_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      lowv_reset_reg <= 1'b0;
    else
      lowv_reset_reg <= flag_reg & enable_reg & action_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      int_reset_reg <= 1'b0;
    else
      int_reset_reg <= other_reset_now | lowv_reset_now;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset cause flags. External reset and power-on-clear wipe them; the
  // other sources only add their own bit so earlier causes survive.

  always_ff @(posedge clk)
  begin
    if (!resetn)
      cause_reg <= `LVDC_CAUSE_RESET;
    else if (poc_active)
      cause_reg <= `LVDC_CAUSE_RESET;
    else
    begin
      if (lowv_reset_now)
        cause_reg[`LVDC_CAUSE_LOWV] <= 1'b1;
      if (wdog_reset_req)
        cause_reg[`LVDC_CAUSE_WDOG] <= 1'b1;
      if (clkmon_reset_req)
        cause_reg[`LVDC_CAUSE_CLKMON] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port. Unmapped addresses read as zero.

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata_reg  <= `LVDC_CTRL_RESET;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= cpu_rd;
      if (!cpu_rd)
        rdata_reg <= rdata_reg;
      else if (lvdc_hit(cpu_addr, `LVDC_CTRL_ADDR))
        rdata_reg <= ctrl_value;
      else if (lvdc_hit(cpu_addr, `LVDC_CAUSE_ADDR))
        rdata_reg <= cause_reg;
      else
        rdata_reg <= `LVDC_CTRL_RESET;
    end
  end

  assign cpu_rdata            = rdata_reg;
  assign cpu_rvalid           = rvalid_reg;
  assign detect_enable        = enable_reg;
  assign reference_gen_enable = refgen_reg;
  assign low_supply_irq       = irq_reg;
  assign internal_reset       = int_reset_reg;
  assign reset_cause_flags    = cause_reg;

endmodule

// >>> verilog/lvdc_defines.svh
// Purpose: Constants for the low voltage detect control block.
// Assumes: 8-bit processor data bus with 16-bit addresses.
// Notes:   Included by the package and by the design modules.
`ifndef LVDC_DEFINES_SVH
`define LVDC_DEFINES_SVH

`define LVDC_CTRL_ADDR       16'hFFBE
`define LVDC_CAUSE_ADDR      16'hFFBD
`define LVDC_CTRL_RESET      8'h00
`define LVDC_CAUSE_RESET     8'h00
`define LVDC_BIT_ENABLE      3'h7
`define LVDC_BIT_REFGEN      3'h4
`define LVDC_BIT_ACTION      3'h1
`define LVDC_BIT_FLAG        3'h0
`define LVDC_CAUSE_LOWV      3'h0
`define LVDC_CAUSE_CLKMON    3'h1
`define LVDC_CAUSE_WDOG      3'h4
`define LVDC_SYNC_WIDTH      3
`define LVDC_SYNC_LOWV       0
`define LVDC_SYNC_POC        1
`define LVDC_SYNC_RAMP       2

`endif

// >>> verilog/lvdc_pkg.sv
// Purpose: Shared types of the low voltage detect control block.
// Assumes: lvdc_defines.svh holds the synchroniser width; byte and address widths are set here.
// Notes:   Types only.
`include "lvdc_defines.svh"

package lvdc_pkg;

  typedef logic [7:0]  lvdc_byte_t;
  typedef logic [15:0] lvdc_addr_t;
  typedef logic [`LVDC_SYNC_WIDTH-1:0] lvdc_sync_t;

endpackage

// >>> verilog/lvdc_sync_if.sv
// Purpose: Carries the raw comparator levels and their synchronised copies.
// Assumes: One clock for both ends.
// Notes:   Bit positions are the LVDC_SYNC_* constants.
`include "lvdc_defines.svh"

interface lvdc_sync_if;

  lvdc_pkg::lvdc_sync_t raw;
  lvdc_pkg::lvdc_sync_t synced;

  modport producer (input raw, output synced);
  modport consumer (output raw, input synced);

endinterface

// >>> verilog/lvdc_sync.sv
// Purpose: Two-flop synchronisers for the analog comparator levels.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The first stage feeds only the second stage.
`include "lvdc_defines.svh"

module lvdc_sync (
  input wire logic       clk,     // System clock.
  input wire logic       resetn,  // Synchronous reset, active low.
  lvdc_sync_if.producer  sif      // Raw levels in, synced levels out.
);

  genvar i;

  generate
    for (i = 0; i < `LVDC_SYNC_WIDTH; i = i + 1)
    begin : g_bit
      logic meta_reg;
      logic sync_reg;

      // The comparators run from their own analog path, so a low supply
      // is still seen as long as the clock source keeps running.
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= sif.raw[i];
          sync_reg <= meta_reg;
        end
      end

      assign sif.synced[i] = sync_reg;
    end
  endgenerate

endmodule

// >>> verif/lvdc_checker.sv
// Purpose: Port assertions for the low voltage control block.
// Assumes: Writes are kept clear of reset sources.
// Notes:   Bound to lvdc_top below.
`include "lvdc_defines.svh"
module lvdc_checker (
  input wire logic                 clk,                  // Clock.
  input wire logic                 resetn,               // Reset.
  input wire lvdc_pkg::lvdc_addr_t cpu_addr,             // Address.
  input wire logic                 cpu_wr,               // Write.
  input wire lvdc_pkg::lvdc_byte_t cpu_wdata,            // Data.
  input wire logic                 supply_low,           // Detector.
  input wire logic                 poc_low,              // Clear.
  input wire logic                 supply_ramp,          // Ramp.
  input wire logic                 wdog_reset_req,       // Watchdog.
  input wire logic                 clkmon_reset_req,     // Clock monitor.
  input wire logic                 detect_enable,        // Bit 7.
  input wire logic                 reference_gen_enable, // Bit 4.
  input wire logic                 low_supply_irq,       // Irq.
  input wire logic                 internal_reset,       // Reset out.
  input wire lvdc_pkg::lvdc_byte_t reset_cause_flags     // Causes.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic quiet;
  // Synchronisers lag, so writes near a source change are not judged.
  assign quiet = !(wdog_reset_req | clkmon_reset_req | internal_reset
    | poc_low | supply_ramp | supply_low);
  sequence s_clear;
    ##3 reset_cause_flags == 8'h00 && !detect_enable;
  endsequence
  property p_rst;
    disable iff (1'b0) !resetn |=> reset_cause_flags == 8'h00
      && !detect_enable && !reference_gen_enable && !internal_reset;
  endproperty
  property p_wr;
    cpu_wr && cpu_addr == `LVDC_CTRL_ADDR && quiet |=>
      detect_enable == $past(cpu_wdata[7])
      && reference_gen_enable == $past(cpu_wdata[4]);
  endproperty
  property p_act;
    $rose(supply_low) && detect_enable |->
      (##4 low_supply_irq) or (##5 internal_reset);
  endproperty
  property p_lv;
    $rose(internal_reset) && supply_low && detect_enable
      |=> reset_cause_flags[0] && detect_enable;
  endproperty
  property p_wdog;
    wdog_reset_req && !internal_reset |=> reset_cause_flags[4]
      && !detect_enable && internal_reset;
  endproperty
  property p_poc;
    $rose(poc_low | supply_ramp) |-> s_clear ##1 internal_reset;
  endproperty
  property p_off;
    !detect_enable [*4] |-> !low_supply_irq;
  endproperty
  property p_flag;
    !supply_low [*5] |-> !low_supply_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  a_wr: assert property (p_wr) else $error("write");
  a_act: assert property (p_act) else $error("action");
  a_lv: assert property (p_lv) else $error("low reset");
  a_wdog: assert property (p_wdog) else $error("watchdog");
  a_poc: assert property (p_poc) else $error("clear");
  a_off: assert property (p_off) else $error("irq gate");
  a_flag: assert property (p_flag) else $error("flag");
endmodule
bind lvdc_top lvdc_checker i_lvdc_checker (.*);

// >>> verif/lvdc_partner.sv
// Purpose: Comparator side model facing the low voltage block.
// Assumes: Levels are analog and move off the clock edge.
// Notes:   The bench asks for dips; the model adds the delay.
module lvdc_partner (
  input  wire logic go_low,      // Supply dip request.
  input  wire logic go_poc,      // Deep dip request.
  input  wire logic go_ramp,     // Power-up request.
  output logic      supply_low,  // Detector comparator.
  output logic      poc_low,     // Clear comparator.
  output logic      supply_ramp  // Power-up in progress.
);
  timeunit 1ns;
  timeprecision 1ns;
  // An odd delay keeps every change clear of both clock edges.
  assign #7 supply_low = go_low;
  assign #7 poc_low = go_poc;
  assign #7 supply_ramp = go_ramp;
endmodule

// >>> verif/tb.sv
// Purpose: Directed bench for the low voltage control block.
// Assumes: 50 ns clock, synchronous active-low reset.
// Notes:   Tasks t_regs to t_poc drive cases and check them; the rest are helpers.
`include "lvdc_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t %h not %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] C = `LVDC_CTRL_ADDR;
  localparam logic [15:0] F = `LVDC_CAUSE_ADDR;
  logic clk, resetn, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, go_low;
  logic go_poc, go_ramp, supply_low, poc_low, supply_ramp, cpu_rvalid;
  logic wdog_reset_req, clkmon_reset_req, detect_enable, low_supply_irq;
  logic reference_gen_enable, internal_reset;
  logic [2:0] cpu_bit_sel;
  lvdc_pkg::lvdc_addr_t cpu_addr;
  lvdc_pkg::lvdc_byte_t cpu_wdata, cpu_rdata, reset_cause_flags;
  int n_fail, checks;
  lvdc_top i_lvdc_top (.*);
  lvdc_partner i_lvdc_partner (.*);
  task automatic final_report;
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    cpu_addr <= C;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic bw(input logic [2:0] s, input logic v);
    @(posedge clk);
    cpu_addr <= C;
    cpu_bit_sel <= s;
    cpu_bit_val <= v;
    cpu_bit_wr <= 1'b1;
    @(posedge clk);
    cpu_bit_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    @(negedge clk);
    `CHK(cpu_rvalid, 1'b1)
    `CHK(cpu_rdata, e)
  endtask
  task automatic wt(input logic v);
    @(negedge clk);
    repeat (20)
      if (internal_reset !== v)
        @(negedge clk);
    `CHK(internal_reset, v)
    if (internal_reset !== v)
      final_report;
  endtask
  task automatic t_regs;
    rd(C, 8'h00);
    rd(F, 8'h00);
    wr(8'hFF);
    rd(C, 8'h92);
    `CHK({detect_enable, reference_gen_enable}, 2'b11)
    bw(3'h7, 1'b0);
    bw(3'h0, 1'b1);
    rd(C, 8'h12);
    wr(8'h00);
    rd(C, 8'h00);
    `CHK({detect_enable, reference_gen_enable}, 2'b00)
  endtask
  task automatic t_irq;
    wr(8'h90);
    rd(C, 8'h90);
    @(posedge clk);
    go_low <= 1'b1;
    cyc(6);
    @(negedge clk);
    `CHK({low_supply_irq, internal_reset}, 2'b10)
    rd(C, 8'h91);
    bw(3'h7, 1'b0);
    cyc(4);
    @(negedge clk);
    `CHK(low_supply_irq, 1'b0)
    rd(C, 8'h10);
    @(posedge clk);
    go_low <= 1'b0;
    cyc(4);
  endtask
  task automatic t_lv;
    wr(8'h92);
    @(posedge clk);
    go_low <= 1'b1;
    wt(1'b1);
    cyc(2);
    @(negedge clk);
    `CHK(reset_cause_flags, 8'h01)
    `CHK(detect_enable, 1'b1)
    @(posedge clk);
    go_low <= 1'b0;
    wt(1'b0);
    cyc(4);
    rd(C, 8'h92);
  endtask
  task automatic t_ext;
    @(posedge clk);
    resetn <= 1'b0;
    cyc(3);
    resetn <= 1'b1;
    rd(C, 8'h00);
    rd(F, 8'h00);
    `CHK(internal_reset, 1'b0)
  endtask
  task automatic t_src;
    @(posedge clk);
    wdog_reset_req <= 1'b1;
    @(posedge clk);
    wdog_reset_req <= 1'b0;
    @(negedge clk);
    `CHK(reset_cause_flags, 8'h10)
    `CHK(detect_enable, 1'b0)
    `CHK(internal_reset, 1'b1)
    wt(1'b0);
    @(posedge clk);
    clkmon_reset_req <= 1'b1;
    @(posedge clk);
    clkmon_reset_req <= 1'b0;
    wt(1'b1);
    wt(1'b0);
    rd(F, 8'h12);
  endtask
  task automatic t_poc;
    wr(8'h92);
    @(posedge clk);
    go_poc <= 1'b1;
    wt(1'b1);
    `CHK(reset_cause_flags, 8'h00)
    `CHK(detect_enable, 1'b0)
    @(posedge clk);
    go_poc <= 1'b0;
    wt(1'b0);
    @(posedge clk);
    go_ramp <= 1'b1;
    wt(1'b1);
    @(posedge clk);
    go_ramp <= 1'b0;
    wt(1'b0);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    {resetn, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, go_low, go_poc} = '0;
    {go_ramp, wdog_reset_req, clkmon_reset_req, cpu_bit_sel} = '0;
    {cpu_addr, cpu_wdata} = '0;
    n_fail = 0;
    checks = 0;
    cyc(3);
    resetn <= 1'b1;
    t_regs;
    t_irq;
    t_lv;
    t_ext;
    t_src;
    t_poc;
    final_report;
  end
endmodule
